// ===== logic/adc_pkg.sv
// Purpose: shared constants and types of the converter control block
// Assumes: 8-bit register port, byte offsets 0 to 6
// Notes:   field positions, reset values and sample lengths live here
package adc_pkg;
	// register offsets
	localparam logic [2:0] OFS_SC1    = 3'h0;
	localparam logic [2:0] OFS_SC2    = 3'h1;
	localparam logic [2:0] OFS_RES_HI = 3'h2;
	localparam logic [2:0] OFS_RES_LO = 3'h3;
	localparam logic [2:0] OFS_CMP_HI = 3'h4;
	localparam logic [2:0] OFS_CMP_LO = 3'h5;
	localparam logic [2:0] OFS_CFG    = 3'h6;
	// first status/control fields
	localparam int SC1_FLAG = 7;
	localparam int SC1_IE   = 6;
	localparam int SC1_CONT = 5;
	// second status/control fields
	localparam int SC2_ACT  = 7;
	localparam int SC2_TRIG = 6;
	localparam int SC2_CMPE = 5;
	localparam int SC2_CMPG = 4;
	// configuration fields
	localparam int CFG_LPWR = 7;
	localparam int CFG_DIV  = 5;
	localparam int CFG_LONG = 4;
	localparam int CFG_MODE = 2;
	localparam int CFG_CLK  = 0;
	// reset values
	localparam logic [7:0] SC1_RESET = 8'h1F;
	localparam logic [7:0] SC2_RESET = 8'h00;
	localparam logic [7:0] CFG_RESET = 8'h00;
	// channel codes
	localparam logic [4:0] CH_LAST_PIN  = 5'h0F;
	localparam logic [4:0] CH_TEMP      = 5'h1A;
	localparam logic [4:0] CH_BANDGAP   = 5'h1B;
	localparam logic [4:0] CH_DISABLED  = 5'h1F;
	// sample lengths in conversion clock ticks and the top trial bit
	localparam logic [4:0] SAMPLE_SHORT = 5'h04;
	localparam logic [4:0] SAMPLE_LONG  = 5'h18;
	localparam logic [3:0] TOP_BIT      = 4'hB;
	typedef enum logic [1:0] {
		CLK_BUS      = 2'b00,
		CLK_BUS_HALF = 2'b01,
		CLK_ALT      = 2'b10,
		CLK_ASYNC    = 2'b11
	} clk_src_t;
	typedef enum logic [1:0] {
		FMT_8  = 2'b00,
		FMT_12 = 2'b01,
		FMT_10 = 2'b10
	} res_fmt_t;
endpackage

// ===== logic/conv_if.sv
// Purpose: carrier between the control logic and the approximation sequencer
// Assumes: one clock domain
// Notes:   ctrl drives the requests, seq answers with state and result
`timescale 1ns/1ps
`default_nettype none
interface conv_if;
	logic        start;
	logic        abort;
	logic        tick;
	logic        long_sample;
	logic        comp_high;
	logic        sampling;
	logic        busy;
	logic        done;
	logic [11:0] trial;
	logic [11:0] result;
	modport ctrl (
		output start, abort, tick, long_sample, comp_high,
		input  sampling, busy, done, trial, result
	);
	modport seq (
		input  start, abort, tick, long_sample, comp_high,
		output sampling, busy, done, trial, result
	);
endinterface
`default_nettype wire

// ===== logic/sar_sequencer.sv
// Purpose: sample phase and bit-by-bit successive approximation
// Assumes: tick is a one-cycle conversion clock enable
// Notes:   comp_high is high while the input is at or above the trial code
`timescale 1ns/1ps
`default_nettype none
module sar_sequencer (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// control side
	conv_if.seq      cv
);
	typedef enum logic [1:0] {
		S_IDLE   = 2'b00,
		S_SAMPLE = 2'b01,
		S_CONV   = 2'b10
	} seq_state_t;
	typedef struct packed {
		seq_state_t  st;
		logic [4:0]  cnt;
		logic [3:0]  bitpos;
		logic [11:0] sar;
		logic [11:0] res;
		logic        done;
	} seq_t;
	seq_t q;
	seq_t d;

	// one-hot weight of a bit position
	function automatic logic [11:0] weight(input logic [3:0] pos);
		weight = 12'(12'h001 << pos);
	endfunction

	// successive approximation, msb first
	always_comb begin
		d = q;
		d.done = 1'b0;
		case (q.st)
			S_SAMPLE: begin
				if (cv.tick) begin
					d.cnt = q.cnt - 5'h01;
					if (q.cnt == 5'h01) begin
						d.st = S_CONV;
						d.bitpos = adc_pkg::TOP_BIT;
						d.sar = weight(adc_pkg::TOP_BIT);
					end
				end
			end
			S_CONV: begin
				if (cv.tick) begin
					d.sar = cv.comp_high ? q.sar : (q.sar & ~weight(q.bitpos));
					if (q.bitpos == 4'h0) begin
						d.st = S_IDLE;
						d.res = d.sar;
						d.done = 1'b1;
						d.sar = 12'h000;
					end else begin
						d.bitpos = q.bitpos - 4'h1;
						d.sar = d.sar | weight(q.bitpos - 4'h1);
					end
				end
			end
			S_IDLE: d.st = S_IDLE;
			default: d.st = S_IDLE;
		endcase
		// abort drops the conversion, a start restarts sampling
		if (cv.abort) begin
			d.st = S_IDLE;
			d.sar = 12'h000;
			d.done = 1'b0;
		end
		if (cv.start) begin
			d.st = S_SAMPLE;
			d.sar = 12'h000;
			d.done = 1'b0;
			d.cnt = cv.long_sample ? adc_pkg::SAMPLE_LONG : adc_pkg::SAMPLE_SHORT;
		end
	end

	// state register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// answers to the control side
	assign cv.sampling = (q.st == S_SAMPLE);
	assign cv.busy     = (q.st != S_IDLE);
	assign cv.done     = q.done;
	assign cv.trial    = q.sar;
	assign cv.result   = q.res;
endmodule
`default_nettype wire

// ===== logic/adc_control.sv
// Purpose: register file, clocking, triggering and result handling of the converter
// Assumes: register port strobes are one cycle; read data one cycle later
// Notes:   the analog mux, sample switch and comparator sit outside
`timescale 1ns/1ps
`default_nettype none
module adc_control (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// register port
	input  wire logic [2:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// clock sources and trigger
	input  wire logic        internal_async_conv_clock,
	input  wire logic        external_reference_clock,
	input  wire logic        hardware_trigger_input,
	// power modes
	input  wire logic        wait_mode,
	input  wire logic        shallow_stop_mode,
	input  wire logic        deep_stop_mode,
	// analog front end
	input  wire logic        comp_high,
	output logic      [4:0]  analog_channel,
	output logic             ext_pin_en,
	output logic             temperature_channel_en,
	output logic             bandgap_channel_en,
	output logic             converter_enable,
	output logic             low_power_en,
	output logic             sample_hold,
	output logic      [11:0] dac_code,
	// interrupt request
	output logic             irq
);
	typedef struct packed {
		logic [4:0]  ch;
		logic        ie;
		logic        cont;
		logic        flag;
		logic        trig;
		logic        cmp_en;
		logic        cmp_gt;
		logic        active;
		logic [11:0] cmp_val;
		logic [11:0] result;
		logic        lpwr;
		logic [1:0]  div;
		logic        longs;
		logic [1:0]  fmt;
		logic [1:0]  clksel;
		logic [2:0]  div_cnt;
		logic        half;
		logic        hw_s1;
		logic        hw_s2;
		logic        hw_s3;
		logic        ack_s1;
		logic        ack_s2;
		logic        ack_s3;
		logic        alt_s1;
		logic        alt_s2;
		logic        alt_s3;
		logic        tick;
		logic        start;
		logic        abort;
		logic [7:0]  rdata;
		logic        irq;
		logic [4:0]  mux;
		logic        pin_en;
		logic        temp_en;
		logic        bg_en;
		logic        conv_en;
	} ctl_t;
	ctl_t q;
	ctl_t d;
	conv_if cv ();

	logic any_stop;
	logic src_tick;
	logic hw_edge;
	logic cmp_true;
	logic [11:0] fmt_res;
	logic can_run;

	// last count of the divider for each divide setting
	function automatic logic [2:0] div_last(input logic [1:0] sel);
		case (sel)
			2'b00:   div_last = 3'h0;
			2'b01:   div_last = 3'h1;
			2'b10:   div_last = 3'h3;
			default: div_last = 3'h7;
		endcase
	endfunction

	// right justification of the raw code
	function automatic logic [11:0] format(input logic [11:0] raw, input logic [1:0] f);
		case (f)
			adc_pkg::FMT_12: format = raw;
			adc_pkg::FMT_10: format = {2'b00, raw[11:2]};
			default:         format = {4'h0, raw[11:4]};
		endcase
	endfunction

	// decoded conditions
	always_comb begin
		any_stop = shallow_stop_mode | deep_stop_mode;
		hw_edge = q.hw_s2 & ~q.hw_s3 & ~deep_stop_mode;
		fmt_res = format(cv.result, q.fmt);
		cmp_true = q.cmp_gt ? (fmt_res >= q.cmp_val) : (fmt_res < q.cmp_val);
		can_run = (q.ch != adc_pkg::CH_DISABLED) & ~deep_stop_mode;
		case (q.clksel)
			adc_pkg::CLK_BUS:      src_tick = ~any_stop;
			adc_pkg::CLK_BUS_HALF: src_tick = ~any_stop & q.half;
			adc_pkg::CLK_ALT:      src_tick = ~any_stop & q.alt_s2 & ~q.alt_s3;
			default:               src_tick = ~deep_stop_mode & q.ack_s2 & ~q.ack_s3;
		endcase
	end

	// next state of the control logic
	always_comb begin
		d = q;
		d.start = 1'b0;
		d.abort = 1'b0;
		d.tick = 1'b0;
		d.rdata = 8'h00;
		// synchronisers, first stage only feeds the second
		d.hw_s1 = hardware_trigger_input;
		d.hw_s2 = q.hw_s1;
		d.hw_s3 = q.hw_s2;
		d.ack_s1 = internal_async_conv_clock;
		d.ack_s2 = q.ack_s1;
		d.ack_s3 = q.ack_s2;
		d.alt_s1 = external_reference_clock;
		d.alt_s2 = q.alt_s1;
		d.alt_s3 = q.alt_s2;
		// conversion clock divider
		d.half = ~q.half;
		if (src_tick) begin
			if (q.div_cnt == div_last(q.div)) begin
				d.div_cnt = 3'h0;
				d.tick = 1'b1;
			end else begin
				d.div_cnt = q.div_cnt + 3'h1;
			end
		end
		// end of a conversion; a done landing just after an abort is stale
		if (cv.done && !q.abort) begin
			d.result = fmt_res;
			d.active = 1'b0;
			if (!q.cmp_en || cmp_true) begin
				d.flag = 1'b1;
			end
			if (q.cont && can_run) begin
				d.start = 1'b1;
				d.active = 1'b1;
			end
		end
		// hardware trigger start
		if (q.trig && hw_edge && can_run && !q.active) begin
			d.start = 1'b1;
			d.active = 1'b1;
		end
		// register reads, low result read clears the flag
		if (reg_rd) begin
			case (reg_addr)
				adc_pkg::OFS_SC1:    d.rdata = {q.flag, q.ie, q.cont, q.ch};
				adc_pkg::OFS_SC2:    d.rdata = {q.active, q.trig, q.cmp_en, q.cmp_gt, 4'h0};
				adc_pkg::OFS_RES_HI: d.rdata = {4'h0, q.result[11:8]};
				adc_pkg::OFS_RES_LO: d.rdata = q.result[7:0];
				adc_pkg::OFS_CMP_HI: d.rdata = {4'h0, q.cmp_val[11:8]};
				adc_pkg::OFS_CMP_LO: d.rdata = q.cmp_val[7:0];
				adc_pkg::OFS_CFG:    d.rdata = {q.lpwr, q.div, q.longs, q.fmt, q.clksel};
				default:             d.rdata = 8'h00;
			endcase
			if (reg_addr == adc_pkg::OFS_RES_LO && !cv.done) begin
				d.flag = 1'b0;
			end
		end
		// register writes
		if (reg_wr) begin
			case (reg_addr)
				adc_pkg::OFS_SC1: begin
					d.ch = reg_wdata[4:0];
					d.ie = reg_wdata[adc_pkg::SC1_IE];
					d.cont = reg_wdata[adc_pkg::SC1_CONT];
					if (!cv.done) begin
						d.flag = 1'b0;
					end
					d.abort = 1'b1;
					d.active = 1'b0;
					d.start = 1'b0;
					if (reg_wdata[4:0] != adc_pkg::CH_DISABLED && !q.trig && !deep_stop_mode) begin
						d.start = 1'b1;
						d.active = 1'b1;
					end
				end
				adc_pkg::OFS_SC2: begin
					d.trig = reg_wdata[adc_pkg::SC2_TRIG];
					d.cmp_en = reg_wdata[adc_pkg::SC2_CMPE];
					d.cmp_gt = reg_wdata[adc_pkg::SC2_CMPG];
				end
				adc_pkg::OFS_CMP_HI: d.cmp_val[11:8] = reg_wdata[3:0];
				adc_pkg::OFS_CMP_LO: d.cmp_val[7:0] = reg_wdata;
				adc_pkg::OFS_CFG: begin
					d.lpwr = reg_wdata[adc_pkg::CFG_LPWR];
					d.div = reg_wdata[adc_pkg::CFG_DIV +: 2];
					d.longs = reg_wdata[adc_pkg::CFG_LONG];
					d.fmt = reg_wdata[adc_pkg::CFG_MODE +: 2];
					d.clksel = reg_wdata[adc_pkg::CFG_CLK +: 2];
				end
				default: d.rdata = d.rdata;
			endcase
		end
		// deep stop halts the converter
		if (deep_stop_mode && q.active) begin
			d.abort = 1'b1;
			d.start = 1'b0;
			d.active = 1'b0;
		end
		// analog routing from the channel field
		d.mux = d.ch;
		d.pin_en = (d.ch <= adc_pkg::CH_LAST_PIN);
		d.temp_en = (d.ch == adc_pkg::CH_TEMP);
		d.bg_en = (d.ch == adc_pkg::CH_BANDGAP);
		d.conv_en = d.active | d.start;
		d.irq = d.flag & d.ie;
	end

	// control register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.ch <= adc_pkg::SC1_RESET[4:0];
			q.mux <= adc_pkg::SC1_RESET[4:0];
			q.ie <= adc_pkg::SC1_RESET[adc_pkg::SC1_IE];
			q.cont <= adc_pkg::SC1_RESET[adc_pkg::SC1_CONT];
			q.trig <= adc_pkg::SC2_RESET[adc_pkg::SC2_TRIG];
			q.cmp_en <= adc_pkg::SC2_RESET[adc_pkg::SC2_CMPE];
			q.cmp_gt <= adc_pkg::SC2_RESET[adc_pkg::SC2_CMPG];
			q.lpwr <= adc_pkg::CFG_RESET[adc_pkg::CFG_LPWR];
			q.div <= adc_pkg::CFG_RESET[adc_pkg::CFG_DIV +: 2];
			q.longs <= adc_pkg::CFG_RESET[adc_pkg::CFG_LONG];
			q.fmt <= adc_pkg::CFG_RESET[adc_pkg::CFG_MODE +: 2];
			q.clksel <= adc_pkg::CFG_RESET[adc_pkg::CFG_CLK +: 2];
		end else begin
			q <= d;
		end
	end

	// requests to the sequencer
	assign cv.start       = q.start;
	assign cv.abort       = q.abort;
	assign cv.tick        = q.tick;
	assign cv.long_sample = q.longs;
	assign cv.comp_high   = comp_high;

	// approximation sequencer
	sar_sequencer u_seq (
		.ref_clk (ref_clk),
		.rst     (rst),
		.cv      (cv)
	);

	// outputs from flip-flops, sample_hold decoded from the sequencer state
	assign reg_rdata              = q.rdata;
	assign analog_channel         = q.mux;
	assign ext_pin_en             = q.pin_en;
	assign temperature_channel_en = q.temp_en;
	assign bandgap_channel_en     = q.bg_en;
	assign converter_enable       = q.conv_en;
	assign low_power_en           = q.lpwr;
	assign sample_hold            = cv.sampling;
	assign dac_code               = cv.trial;
	assign irq                    = q.irq;
endmodule
`default_nettype wire

// ===== testbench/adc_control_properties.sv
// Purpose: port properties of the converter control block
// Assumes: one clock, async active-high reset
// Notes:   bound to every adc_control instance
`timescale 1ns/1ps
`default_nettype none
module adc_control_properties (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        rst,
	// register port
	input wire logic [2:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	// power mode
	input wire logic        deep_stop_mode,
	// front end and interrupt
	input wire logic [4:0]  analog_channel,
	input wire logic        ext_pin_en,
	input wire logic        temperature_channel_en,
	input wire logic        bandgap_channel_en,
	input wire logic        converter_enable,
	input wire logic        low_power_en,
	input wire logic        sample_hold,
	input wire logic [11:0] dac_code,
	input wire logic        irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// decoded strobes
	wire sc1_wr = reg_wr && reg_addr == adc_pkg::OFS_SC1;
	wire lo_rd  = reg_rd && reg_addr == adc_pkg::OFS_RES_LO;
	AST_CH_PIN: assert property (sc1_wr |=> analog_channel == $past(reg_wdata[4:0])
		&& ext_pin_en == ($past(reg_wdata[4:0]) <= 5'h0F)) else $error("pin decode");
	AST_CH_INT: assert property (sc1_wr |=> temperature_channel_en ==
		($past(reg_wdata[4:0]) == 5'h1A) && bandgap_channel_en == ($past(reg_wdata[4:0]) == 5'h1B))
		else $error("internal channel decode");
	AST_OFF: assert property (sc1_wr && reg_wdata[4:0] == 5'h1F |=> !converter_enable)
		else $error("converter not off");
	AST_DEEP: assert property (deep_stop_mode [*4] |-> !converter_enable)
		else $error("runs in deep stop");
	AST_LPWR: assert property (reg_wr && reg_addr == adc_pkg::OFS_CFG |=>
		low_power_en == $past(reg_wdata[7])) else $error("low power bit");
	AST_SAMPLE: assert property (sample_hold |-> dac_code == 12'h000)
		else $error("trial during sample");
	AST_FIRST: assert property ($rose(dac_code[11]) && $past(dac_code) == 12'h000
		|-> dac_code == 12'h800) else $error("first trial code");
	AST_CLR: assert property ((sc1_wr || lo_rd) && !converter_enable |-> ##2 !irq)
		else $error("flag not cleared");
	AST_RDATA: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("stray read data");
endmodule
bind adc_control adc_control_properties u_adc_control_properties (
	.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.deep_stop_mode(deep_stop_mode), .analog_channel(analog_channel),
	.ext_pin_en(ext_pin_en), .temperature_channel_en(temperature_channel_en),
	.bandgap_channel_en(bandgap_channel_en), .converter_enable(converter_enable),
	.low_power_en(low_power_en), .sample_hold(sample_hold), .dac_code(dac_code), .irq(irq));
`default_nettype wire

// ===== testbench/adc_control_tb_top.sv
// Purpose: self-checking bench for adc_control
// Assumes: comparator modelled as ideal against vin
// Notes:   read answers are queued and checked by a monitor
`timescale 1ns/1ps
`default_nettype none
module adc_control_tb_top;
	logic        ref_clk = 0;
	logic        rst = 1;
	logic [2:0]  reg_addr = 0;
	logic [7:0]  reg_wdata = 0;
	logic        reg_wr = 0;
	logic        reg_rd = 0;
	logic        alt_clk = 0;
	logic        async_clk = 0;
	logic        hw = 0;
	logic        wm = 0;
	logic        ssm = 0;
	logic        dsm = 0;
	logic        rd_pend = 0;
	logic [11:0] vin = 0;
	logic [7:0]  reg_rdata;
	logic [4:0]  ch;
	logic        pin_en, temp_en, bg_en, conv_en, lp_en, sh, irq;
	logic [11:0] dac;
	logic [7:0]  expq[$];
	logic [4:0]  codes[6] = '{5'h00, 5'h0F, 5'h10, 5'h19, 5'h1A, 5'h1B};
	int          fails = 0;
	int          samples_checked = 0;
	wire         comp_w = vin >= dac;
	// bus clock and two unrelated sources
	always #5 ref_clk = ~ref_clk;
	always #21 alt_clk = ~alt_clk;
	always #25 async_clk = ~async_clk;
	adc_control u_adc_control (
		.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.internal_async_conv_clock(async_clk), .external_reference_clock(alt_clk),
		.hardware_trigger_input(hw), .wait_mode(wm), .shallow_stop_mode(ssm),
		.deep_stop_mode(dsm), .comp_high(comp_w), .analog_channel(ch),
		.ext_pin_en(pin_en), .temperature_channel_en(temp_en), .bandgap_channel_en(bg_en),
		.converter_enable(conv_en), .low_power_en(lp_en), .sample_hold(sh),
		.dac_code(dac), .irq(irq));
	task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// read data checked in the cycle after the strobe
	always @(posedge ref_clk) begin
		if (rd_pend) chk("rdata", {4'h0, reg_rdata}, {4'h0, expq.pop_front()});
		rd_pend <= reg_rd;
	end
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		expq.push_back(e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
	endtask
	// one conversion of n ticks at p cycles a tick
	task automatic conv(input logic [7:0] cfg, input logic [7:0] sc2, input logic [11:0] v,
			input int n, input int p, input bit go);
		int c;
		logic [11:0] r;
		c = 0;
		vin <= v;
		wr(adc_pkg::OFS_CFG, cfg);
		wr(adc_pkg::OFS_SC2, sc2);
		wr(adc_pkg::OFS_SC1, 8'h45);
		if (sc2[6]) begin
			rd(adc_pkg::OFS_SC2, sc2);
			hw <= 1'b1;
		end
		while (irq !== 1'b1 && c < n * p + p + 16) begin
			@(posedge ref_clk);
			c++;
		end
		hw <= 1'b0;
		chk("done", 12'(irq === 1'b1 && c >= n * p - p), 12'(go));
		if (go) begin
			r = cfg[3:2] == 2'b01 ? v : (cfg[3:2] == 2'b10 ? v >> 2 : v >> 4);
			rd(adc_pkg::OFS_RES_HI, {4'h0, r[11:8]});
			rd(adc_pkg::OFS_RES_LO, r[7:0]);
			rd(adc_pkg::OFS_SC1, 8'h45);
			rd(adc_pkg::OFS_SC2, sc2);
			chk("irq", 12'(irq), 12'h000);
		end
	endtask
	// main sequence
	initial begin
		logic [11:0] cv;
		logic [11:0] v;
		void'($urandom(34));
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		chk("ch", 12'(ch), 12'h01F);
		rd(adc_pkg::OFS_SC1, 8'h1F);
		rd(adc_pkg::OFS_SC2, 8'h00);
		rd(adc_pkg::OFS_CFG, 8'h00);
		rd(3'h7, 8'h00);
		// bus clock at every divide, then bus/2 long sample 10-bit
		for (int d = 0; d < 4; d++)
			conv(8'h04 | 8'(d << 5), 8'h00, 12'($urandom), 16, 1 << d, 1'b1);
		conv(8'h99, 8'h00, 12'($urandom), 36, 2, 1'b1);
		conv(8'h02, 8'h00, 12'($urandom), 16, 4, 1'b1);
		conv(8'h07, 8'h00, 12'($urandom), 16, 5, 1'b1);
		// alternate source runs in wait, stalls in shallow stop
		wm <= 1'b1;
		conv(8'h02, 8'h00, 12'($urandom), 16, 4, 1'b1);
		wm <= 1'b0;
		ssm <= 1'b1;
		conv(8'h02, 8'h00, 12'($urandom), 16, 4, 1'b0);
		dsm <= 1'b1;
		repeat (6) @(posedge ref_clk);
		rd(adc_pkg::OFS_SC2, 8'h00);
		dsm <= 1'b0;
		// hardware trigger in shallow stop, then in run
		conv(8'h07, 8'h40, 12'($urandom), 16, 5, 1'b1);
		ssm <= 1'b0;
		conv(8'h04, 8'h40, 12'($urandom), 16, 1, 1'b1);
		// compare both ways, equal values on the last two
		for (int i = 0; i < 4; i++) begin
			cv = 12'($urandom);
			v = (i > 1) ? cv : 12'($urandom);
			wr(adc_pkg::OFS_CMP_HI, {4'h0, cv[11:8]});
			wr(adc_pkg::OFS_CMP_LO, cv[7:0]);
			conv(8'h04, {3'b001, i[0], 4'h0}, v, 16, 1, i[0] ? v >= cv : v < cv);
		end
		// continuous mode keeps restarting, flag stays set
		wr(adc_pkg::OFS_SC2, 8'h00);
		wr(adc_pkg::OFS_SC1, 8'h25);
		repeat (45) @(posedge ref_clk);
		rd(adc_pkg::OFS_SC2, 8'h80);
		rd(adc_pkg::OFS_SC1, 8'hA5);
		// restart then switch off mid-conversion
		wr(adc_pkg::OFS_SC1, 8'h05);
		rd(adc_pkg::OFS_SC2, 8'h80);
		wr(adc_pkg::OFS_SC1, 8'h1F);
		repeat (40) @(posedge ref_clk);
		rd(adc_pkg::OFS_SC2, 8'h00);
		rd(adc_pkg::OFS_SC1, 8'h1F);
		// channel decode over pin, reserved and internal codes
		foreach (codes[k]) begin
			wr(adc_pkg::OFS_SC1, {3'h0, codes[k]});
			@(negedge ref_clk);
			chk("pin", 12'(pin_en), 12'(codes[k] <= 5'h0F));
			chk("temp", 12'(temp_en), 12'(codes[k] == 5'h1A));
			chk("bg", 12'(bg_en), 12'(codes[k] == 5'h1B));
		end
		wr(adc_pkg::OFS_SC1, 8'h1F);
		tally_and_finish;
	end
	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge ref_clk);
		fails++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
